// file: hw/shift_move_indirect_exec.sv
// Executor for the right shift, file move, indirect load and bank load.
// Assumes an APB master; instructions are launched by a register write.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// How it works
// RULE1: shift file right, bit 0 to carry
// RULE2: zero into bit 7; update carry, zero
// RULE3: shift result to acc or file
// RULE4: move file register selected by f
// RULE5: move result to acc or file
// RULE6: move sets zero flag, single cycle; here fetch and commit take two clocks
// RULE7: indirect load into acc, sets zero
// RULE8: mode code picks pointer update
// RULE9: pre modes adjust before access
// RULE10: offset form adds signed literal only
// RULE11: pointer ends plus/minus one or unchanged
// RULE12: pointer wraps silently at 16 bits
// RULE13: window addresses redirect through pointer
// RULE14: bank literal load, flags untouched
// RULE15: pointer steps never touch flags
// RULE16: commit at end of execute
module shift_move_indirect_exec (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [31:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    import shift_move_pkg::*;

    // ==========================================================
    // Execute sequencer
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_COMMIT
    } exec_state_t;

    exec_state_t state_ff, nxt_state; // Sequencer state
    logic [INSTR_W-1:0] instr_ff, nxt_instr; // Latched instruction
    logic [MEM_AW-1:0] eaddr_ff, nxt_eaddr; // Operand address
    logic [DATA_W-1:0] acc_ff, nxt_acc; // Working register
    flags_t flags_ff, nxt_flags; // Carry and zero
    logic [BANK_W-1:0] bank_select_reg_ff, nxt_bank_select_reg; // Bank select
    logic [PTR_W-1:0] indirect_pointer_ff [2]; // Two pointers
    logic [PTR_W-1:0] nxt_indirect_pointer [2]; // Pointer next values
    logic [MEM_AW-1:0] mem_addr_ff, nxt_mem_addr; // Software memory index
    logic ack_ff, nxt_ack; // Ready to the bus
    logic err_ff, nxt_err; // Slave error to the bus
    logic [31:0] prdata_ff, nxt_prdata; // Read data to the bus
    logic view_ok_ff, nxt_view_ok; // Read port shows mem_addr_ff

    // ==========================================================
    // Instruction fields
    logic [3:0] opc; // Operation code
    logic dest_file; // Destination bit
    logic [FADDR_W-1:0] faddr; // File address
    logic ind_n; // Pointer choice
    pointer_update_mode_t pointer_update_mode; // Update mode
    logic [OFS_W-1:0] ofs_k; // Signed offset literal
    logic [BANK_W-1:0] bank_k; // Bank literal
    logic is_ind; // Any indirect load
    logic [PTR_W-1:0] ptr_cur; // Selected pointer
    logic [PTR_W-1:0] eff_ptr; // Indirect access address
    logic [MEM_AW-1:0] eff_addr; // Memory address of operand

    // Field extraction
    always_comb begin
        opc = instr_ff[OPC_LSB +: 4];
        dest_file = instr_ff[DEST_BIT];
        faddr = instr_ff[FADDR_W-1:0];
        is_ind = (opc == OP_IND_MODE) || (opc == OP_IND_OFS);
        ind_n = (opc == OP_IND_OFS) ? instr_ff[OFS_NSEL_BIT] : instr_ff[NSEL_BIT];
        pointer_update_mode = pointer_update_mode_t'(instr_ff[1:0]);
        ofs_k = instr_ff[OFS_W-1:0];
        bank_k = instr_ff[BANK_W-1:0];
    end

    // ==========================================================
    // Operand address
    // Access address from pointer, mode or offset
    always_comb begin
        ptr_cur = indirect_pointer_ff[ind_n];
        eff_ptr = ptr_cur;
        if (opc == OP_IND_OFS) begin
            // RULE10: pointer plus signed k
            eff_ptr = ptr_cur + {{(PTR_W-OFS_W){ofs_k[OFS_W-1]}}, ofs_k};
        end else begin
            // RULE8: mode code selects step
            // RULE9: pre modes step first
            unique case (pointer_update_mode)
                MODE_PRE_INC: eff_ptr = ptr_cur + 16'h0001;
                MODE_PRE_DEC: eff_ptr = ptr_cur - 16'h0001;
                MODE_POST_INC: eff_ptr = ptr_cur;
                MODE_POST_DEC: eff_ptr = ptr_cur;
            endcase
        end
        if (is_ind) begin
            // RULE7: indirect target
            eff_addr = eff_ptr[MEM_AW-1:0];
        end else if (faddr == WIN0_ADDR) begin
            // RULE13: window through pointer 0
            eff_addr = indirect_pointer_ff[0][MEM_AW-1:0];
        end else if (faddr == WIN1_ADDR) begin
            // Window through pointer 1
            eff_addr = indirect_pointer_ff[1][MEM_AW-1:0];
        end else begin
            // RULE4: banked direct address
            eff_addr = {bank_select_reg_ff[0], faddr};
        end
    end

    // ==========================================================
    // Memory port
    mem_req_t mem_req; // Request to memory
    logic [DATA_W-1:0] mem_rdata; // Registered read word
    logic [DATA_W-1:0] shift_res; // Shift result
    logic acc_phase; // Bus access cycle still waiting
    logic bus_wr; // Bus write taking effect
    logic bus_rd; // Bus read taking effect
    logic [7:0] reg_off; // Register offset
    logic mapped; // Offset decodes
    logic bus_ok; // Bus transfer may complete

    data_mem u_mem (
        .clk(SYS_CLK),
        .rst(RST),
        .req(mem_req),
        .rdata(mem_rdata)
    );

    // Memory request mux
    always_comb begin
        mem_req.we = 1'b0;
        mem_req.addr = mem_addr_ff;
        mem_req.wdata = PWDATA[DATA_W-1:0];
        if (state_ff == ST_FETCH) begin
            // Operand read
            mem_req.addr = eff_addr;
        end else if (state_ff == ST_COMMIT) begin
            // RULE3: file write when d set
            mem_req.addr = eaddr_ff;
            mem_req.wdata = (opc == OP_SHIFT) ? shift_res : mem_rdata;
            // RULE5: move rewrites the file
            mem_req.we = dest_file && ((opc == OP_SHIFT) || (opc == OP_MOVE));
        end else if (bus_wr && (reg_off == REG_MEM_DATA)) begin
            // Software memory write
            mem_req.we = 1'b1;
        end
    end

    // ==========================================================
    // Bus decode
    always_comb begin
        reg_off = PADDR[7:0];
        mapped = (PADDR[31:8] == 24'h000000) && (PADDR[1:0] == 2'b00)
            && (reg_off <= REG_MEM_DATA);
        acc_phase = PSEL && PENABLE && !ack_ff;
        // Stall while executing; memory reads need a settled port
        bus_ok = (state_ff == ST_IDLE)
            && (PWRITE || (reg_off != REG_MEM_DATA) || view_ok_ff);
        bus_wr = acc_phase && bus_ok && PWRITE && mapped;
        bus_rd = acc_phase && bus_ok && !PWRITE && mapped;
    end

    // ==========================================================
    // Architectural state and bus slave next values
    always_comb begin
        nxt_state = state_ff;
        nxt_instr = instr_ff;
        nxt_eaddr = eaddr_ff;
        nxt_acc = acc_ff;
        nxt_flags = flags_ff;
        nxt_bank_select_reg = bank_select_reg_ff;
        nxt_mem_addr = mem_addr_ff;
        nxt_ack = 1'b0;
        nxt_err = 1'b0;
        nxt_prdata = prdata_ff;
        nxt_view_ok = (state_ff == ST_IDLE);
        // RULE2: zero into the top bit
        shift_res = {1'b0, mem_rdata[DATA_W-1:1]};
        if (acc_phase && bus_ok) begin
            // Answer the access phase
            nxt_ack = 1'b1;
            nxt_err = !mapped;
        end
        if (bus_rd) begin
            // Register read mux
            nxt_prdata = 32'h00000000;
            unique case (reg_off)
                REG_INSTR: nxt_prdata[INSTR_W-1:0] = instr_ff;
                REG_ACC: nxt_prdata[DATA_W-1:0] = acc_ff;
                REG_STATUS: begin
                    nxt_prdata[ST_C_BIT] = flags_ff.c;
                    nxt_prdata[ST_Z_BIT] = flags_ff.z;
                end
                REG_BANK: nxt_prdata[BANK_W-1:0] = bank_select_reg_ff;
                REG_PTR0: nxt_prdata[PTR_W-1:0] = indirect_pointer_ff[0];
                REG_PTR1: nxt_prdata[PTR_W-1:0] = indirect_pointer_ff[1];
                REG_MEM_ADDR: nxt_prdata[MEM_AW-1:0] = mem_addr_ff;
                REG_MEM_DATA: nxt_prdata[DATA_W-1:0] = mem_rdata;
                default: nxt_prdata = 32'h00000000;
            endcase
        end
        if (bus_wr) begin
            // Register writes
            unique case (reg_off)
                REG_INSTR: begin
                    // Launch an instruction
                    nxt_instr = PWDATA[INSTR_W-1:0];
                    nxt_state = ST_FETCH;
                end
                REG_ACC: nxt_acc = PWDATA[DATA_W-1:0];
                REG_STATUS: begin
                    nxt_flags.c = PWDATA[ST_C_BIT];
                    nxt_flags.z = PWDATA[ST_Z_BIT];
                end
                REG_BANK: nxt_bank_select_reg = PWDATA[BANK_W-1:0];
                REG_MEM_ADDR: nxt_mem_addr = PWDATA[MEM_AW-1:0];
                default: nxt_mem_addr = mem_addr_ff;
            endcase
            nxt_view_ok = 1'b0;
        end
        unique case (state_ff)
            ST_IDLE: begin
                // Waiting for a launch
                nxt_eaddr = eaddr_ff;
            end
            ST_FETCH: begin
                // Hold operand address for the commit
                nxt_eaddr = eff_addr;
                nxt_state = ST_COMMIT;
            end
            ST_COMMIT: begin
                // RULE16: commit ends the execute
                nxt_state = ST_IDLE;
                unique case (opc)
                    OP_SHIFT: begin
                        // RULE1: bit 0 into carry
                        nxt_flags.c = mem_rdata[0];
                        nxt_flags.z = (shift_res == 8'h00);
                        if (!dest_file) begin
                            nxt_acc = shift_res;
                        end
                    end
                    OP_MOVE: begin
                        // RULE6: zero follows moved value
                        nxt_flags.z = (mem_rdata == 8'h00);
                        if (!dest_file) begin
                            nxt_acc = mem_rdata;
                        end
                    end
                    OP_IND_MODE, OP_IND_OFS: begin
                        // RULE15: only loaded data sets zero
                        nxt_acc = mem_rdata;
                        nxt_flags.z = (mem_rdata == 8'h00);
                    end
                    OP_BANK: begin
                        // RULE14: bank literal, flags kept
                        nxt_bank_select_reg = bank_k;
                    end
                    default: begin
                        // Unknown code acts as no operation
                        nxt_acc = acc_ff;
                    end
                endcase
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // ==========================================================
    // Pointer update, one copy per pointer
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ptr
            // Next value of one pointer
            always_comb begin
                nxt_indirect_pointer[gi] = indirect_pointer_ff[gi];
                if (bus_wr && (reg_off == ((gi == 0) ? REG_PTR0 : REG_PTR1))) begin
                    // Software load
                    nxt_indirect_pointer[gi] = PWDATA[PTR_W-1:0];
                end else if ((state_ff == ST_COMMIT) && (opc == OP_IND_MODE)
                    && (ind_n == 1'(gi))) begin
                    // RULE11: step by one; RULE12: wraps freely
                    unique case (pointer_update_mode)
                        MODE_PRE_INC, MODE_POST_INC:
                            nxt_indirect_pointer[gi] = indirect_pointer_ff[gi] + 16'h0001;
                        MODE_PRE_DEC, MODE_POST_DEC:
                            nxt_indirect_pointer[gi] = indirect_pointer_ff[gi] - 16'h0001;
                    endcase
                end
            end

            // Pointer register
            always_ff @(posedge SYS_CLK or posedge RST) begin
                if (RST) begin
                    indirect_pointer_ff[gi] <= RST_PTR;
                end else begin
                    indirect_pointer_ff[gi] <= nxt_indirect_pointer[gi];
                end
            end
        end
    endgenerate

    // ==========================================================
    // State registers
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_ff <= ST_IDLE;
            instr_ff <= '0;
            eaddr_ff <= '0;
            acc_ff <= RST_ACC;
            flags_ff <= '0;
            bank_select_reg_ff <= RST_BANK;
            mem_addr_ff <= '0;
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            view_ok_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            instr_ff <= nxt_instr;
            eaddr_ff <= nxt_eaddr;
            acc_ff <= nxt_acc;
            flags_ff <= nxt_flags;
            bank_select_reg_ff <= nxt_bank_select_reg;
            mem_addr_ff <= nxt_mem_addr;
            ack_ff <= nxt_ack;
            err_ff <= nxt_err;
            prdata_ff <= nxt_prdata;
            view_ok_ff <= nxt_view_ok;
        end
    end

    // Bus outputs from flip-flops
    assign PRDATA = prdata_ff;
    assign PREADY = ack_ff;
    assign PSLVERR = err_ff;

endmodule // shift_move_indirect_exec

// file: shared/shift_move_pkg.sv
// Constants, codes and carrier types for the shift/move/indirect executor.
// Assumes a byte-wide data memory reached through the little memory module.
package shift_move_pkg;

    // ==========================================================
    // Widths
    localparam int DATA_W = 8;
    localparam int PTR_W = 16;
    localparam int BANK_W = 5;
    localparam int FADDR_W = 7;
    localparam int MEM_AW = 8;
    localparam int MEM_DEPTH = 256;
    localparam int INSTR_W = 16;
    localparam int OFS_W = 6;

    // ==========================================================
    // Instruction word layout
    localparam int OPC_LSB = 12;
    localparam int DEST_BIT = 7;
    localparam int NSEL_BIT = 2;
    localparam int OFS_NSEL_BIT = 6;
    localparam logic [3:0] OP_SHIFT = 4'h1;
    localparam logic [3:0] OP_MOVE = 4'h2;
    localparam logic [3:0] OP_IND_MODE = 4'h3;
    localparam logic [3:0] OP_IND_OFS = 4'h4;
    localparam logic [3:0] OP_BANK = 4'h5;
    localparam logic [FADDR_W-1:0] WIN0_ADDR = 7'h00;
    localparam logic [FADDR_W-1:0] WIN1_ADDR = 7'h01;

    // Pointer update modes
    typedef enum logic [1:0] {
        MODE_PRE_INC = 2'b00,
        MODE_PRE_DEC = 2'b01,
        MODE_POST_INC = 2'b10,
        MODE_POST_DEC = 2'b11
    } pointer_update_mode_t;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] REG_INSTR = 8'h00;
    localparam logic [7:0] REG_ACC = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_BANK = 8'h0c;
    localparam logic [7:0] REG_PTR0 = 8'h10;
    localparam logic [7:0] REG_PTR1 = 8'h14;
    localparam logic [7:0] REG_MEM_ADDR = 8'h18;
    localparam logic [7:0] REG_MEM_DATA = 8'h1c;
    localparam int ST_C_BIT = 0;
    localparam int ST_Z_BIT = 1;
    localparam int ST_BUSY_BIT = 31;

    // Reset values
    localparam logic [DATA_W-1:0] RST_ACC = 8'h00;
    localparam logic [BANK_W-1:0] RST_BANK = 5'h00;
    localparam logic [PTR_W-1:0] RST_PTR = 16'h0000;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic we;
        logic [MEM_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic z;
        logic c;
    } flags_t;

endpackage

// file: hw/data_mem.sv
// Byte-wide single-port data memory with a registered read port.
// Assumes one request per cycle; a write returns the old word that cycle.
`timescale 1ns/10ps
module data_mem (
    input wire logic clk,
    input wire logic rst,
    input shift_move_pkg::mem_req_t req,
    output logic [shift_move_pkg::DATA_W-1:0] rdata
);
    import shift_move_pkg::*;

    // ==========================================================
    // Storage
    logic [DATA_W-1:0] mem_ff [MEM_DEPTH]; // Data bytes, no reset
    logic [DATA_W-1:0] rdata_ff; // Registered read word

    // Array write, no reset
    always_ff @(posedge clk) begin
        if (req.we) begin
            mem_ff[req.addr] <= req.wdata;
        end
    end

    // Read register, cleared by reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= mem_ff[req.addr];
        end
    end

    assign rdata = rdata_ff;

endmodule // data_mem

// file: test/shift_move_indirect_exec_sva.sv
// Checker for the executor's APB port and its register side effects.
// Sees only top-level ports; bound onto every executor instance.
`timescale 1ns/10ps
module shift_move_indirect_exec_sva (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [31:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR
);
    import shift_move_pkg::*;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // ==========================================================
    // Shadow state
    logic wdone; // Accepted write this cycle
    logic [4:0] bank_ff, nxt_bank;
    logic [1:0][15:0] ptr_ff, nxt_ptr;
    logic c_ff, nxt_c;
    logic c_ok_ff, nxt_c_ok; // Carry known: no shift since reset or the last status write
    assign wdone = PSEL && PENABLE && PREADY && !PSLVERR && PWRITE;
    // Next shadow values from accepted writes
    always_comb begin
        nxt_bank = bank_ff;
        nxt_ptr = ptr_ff;
        nxt_c = c_ff;
        nxt_c_ok = c_ok_ff;
        if (wdone && PADDR == {24'h0, REG_BANK}) begin
            nxt_bank = PWDATA[4:0];
        end
        if (wdone && PADDR[31:3] == 29'h2) begin
            nxt_ptr[PADDR[2]] = PWDATA[15:0];
        end
        if (wdone && PADDR == {24'h0, REG_STATUS}) begin
            nxt_c = PWDATA[0];
            nxt_c_ok = 1'b1;
        end
        if (wdone && PADDR == {24'h0, REG_INSTR}) begin
            case (PWDATA[15:12])
                OP_SHIFT: nxt_c_ok = 1'b0;
                // Step wraps at 16 bits
                OP_IND_MODE: nxt_ptr[PWDATA[2]] = ptr_ff[PWDATA[2]] +
                    (PWDATA[0] ? 16'hffff : 16'h0001);
                OP_BANK: nxt_bank = PWDATA[4:0];
                default: ;
            endcase
        end
    end
    // Register the shadows
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            bank_ff <= '0;
            ptr_ff <= '0;
            c_ff <= 1'b0;
            c_ok_ff <= 1'b1;
        end else begin
            bank_ff <= nxt_bank;
            ptr_ff <= nxt_ptr;
            c_ff <= nxt_c;
            c_ok_ff <= nxt_c_ok;
        end
    end
    // ==========================================================
    // Sequences and assertions
    sequence s_access_open;
        PSEL && $rose(PENABLE);
    endsequence
    sequence s_read_of(logic [7:0] a);
        PSEL && PENABLE && PREADY && !PSLVERR && !PWRITE && PADDR == {24'h0, a};
    endsequence
    ready_late_a: assert property (s_access_open |-> !PREADY)
        else $error("ready in first access cycle");
    ready_bound_a: assert property (s_access_open |-> ##[1:8] PREADY)
        else $error("no ready within bound");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    err_unmapped_a: assert property (PSEL && PENABLE && PREADY &&
        (PADDR[31:5] != 27'h0 || PADDR[1:0] != 2'h0) |-> PSLVERR)
        else $error("unmapped access not refused");
    bank_track_a: assert property (s_read_of(REG_BANK) |-> PRDATA == {27'h0, bank_ff})
        else $error("bank value wrong");
    ptr_zero_a: assert property (s_read_of(REG_PTR0) |-> PRDATA[15:0] == ptr_ff[0])
        else $error("pointer zero wrong");
    ptr_one_a: assert property (s_read_of(REG_PTR1) |-> PRDATA[15:0] == ptr_ff[1])
        else $error("pointer one wrong");
    carry_keep_a: assert property (s_read_of(REG_STATUS) ##0 c_ok_ff |-> PRDATA[0] == c_ff)
        else $error("carry changed");
    acc_width_a: assert property (s_read_of(REG_ACC) |-> PRDATA[31:8] == 24'h0)
        else $error("acc upper bits set");
endmodule // shift_move_indirect_exec_sva

bind shift_move_indirect_exec shift_move_indirect_exec_sva u_shift_move_indirect_exec_sva (
    .SYS_CLK(SYS_CLK), .RST(RST), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

// file: test/apb_master.sv
// APB master model standing on the executor's register port.
// Assumes the caller's clock; one transfer at a time.
`timescale 1ns/10ps
module apb_master (
    input wire logic clk,
    output logic [31:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus from time zero
    initial begin
        paddr = 32'h0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
    end
    // Setup, access, hold until ready is sampled high
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // apb_master

// file: test/tb_shift_move_indirect_exec.sv
// Self-checking bench for the executor, driven over APB.
// Assumes the package constants for offsets and opcodes.
`timescale 1ns/10ps
module tb_shift_move_indirect_exec;
    import shift_move_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic psel, penable, pwrite, pready, pslverr, err;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [7:0] ea [4] = '{8'h11, 8'h0f, 8'h10, 8'h10}; // Access address per mode
    logic [15:0] fp [4] = '{16'h11, 16'h0f, 16'h11, 16'h0f}; // Final pointer per mode
    always #2.5 sys_clk = ~sys_clk;
    // ==========================================================
    // Instances
    shift_move_indirect_exec u_shift_move_indirect_exec (.SYS_CLK(sys_clk), .RST(rst),
        .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    apb_master u_apb_master (.clk(sys_clk), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ==========================================================
    // Tasks
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_apb_master.xfer(1'b1, {24'h0, a}, d, rd, err);
        check({31'h0, err}, 32'h0, "write refused");
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        u_apb_master.xfer(1'b0, {24'h0, a}, 32'h0, rd, err);
        check(rd, exp, what);
    endtask
    task automatic mem_wr(input logic [7:0] a, input logic [7:0] d);
        wr(REG_MEM_ADDR, {24'h0, a});
        wr(REG_MEM_DATA, {24'h0, d});
    endtask
    task automatic mem_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        wr(REG_MEM_ADDR, {24'h0, a});
        rdchk(REG_MEM_DATA, {24'h0, exp}, what);
    endtask
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    // ==========================================================
    // Test sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rdchk(REG_ACC, 32'h0, "acc rst");
        rdchk(REG_STATUS, 32'h0, "status rst");
        rdchk(REG_BANK, 32'h0, "bank rst");
        $display("test reset done");
        mem_wr(8'h25, 8'h81);
        wr(REG_STATUS, 32'h2);
        wr(REG_INSTR, 32'h1025);
        rdchk(REG_ACC, 32'h40, "shift acc");
        rdchk(REG_STATUS, 32'h1, "shift flags");
        mem_chk(8'h25, 8'h81, "shift src kept");
        mem_wr(8'h26, 8'h01);
        wr(REG_INSTR, 32'h10a6);
        mem_chk(8'h26, 8'h00, "shift file");
        rdchk(REG_STATUS, 32'h3, "shift zero");
        $display("test shift done");
        wr(REG_STATUS, 32'h1);
        mem_wr(8'h30, 8'h00);
        wr(REG_INSTR, 32'h2030);
        rdchk(REG_ACC, 32'h0, "move acc");
        rdchk(REG_STATUS, 32'h3, "move zero");
        mem_wr(8'h31, 8'h7e);
        wr(REG_INSTR, 32'h20b1);
        mem_chk(8'h31, 8'h7e, "move file");
        rdchk(REG_STATUS, 32'h1, "move test");
        rdchk(REG_ACC, 32'h0, "move acc kept");
        $display("test move done");
        wr(REG_STATUS, 32'h3);
        wr(REG_INSTR, 32'h501f);
        rdchk(REG_BANK, 32'h1f, "bank load");
        rdchk(REG_STATUS, 32'h3, "bank flags");
        mem_wr(8'ha5, 8'h9c);
        wr(REG_INSTR, 32'h2025);
        rdchk(REG_ACC, 32'h9c, "banked move");
        wr(REG_INSTR, 32'h5000);
        rdchk(REG_BANK, 32'h0, "bank zero");
        $display("test bank done");
        for (int a = 15; a < 18; a++) begin
            mem_wr(a[7:0], a[7:0] + 8'h40);
        end
        for (int m = 0; m < 4; m++) begin
            wr(REG_STATUS, 32'h1);
            wr(REG_PTR0, 32'h10);
            wr(REG_INSTR, {16'h0, 4'h3, 10'h0, m[1:0]});
            rdchk(REG_ACC, {24'h0, ea[m] + 8'h40}, "mode load");
            rdchk(REG_PTR0, {16'h0, fp[m]}, "mode ptr");
            rdchk(REG_STATUS, 32'h1, "mode flags");
        end
        mem_wr(8'h00, 8'h00);
        wr(REG_PTR1, 32'hffff);
        wr(REG_INSTR, 32'h3004);
        rdchk(REG_PTR1, 32'h0, "wrap up");
        rdchk(REG_STATUS, 32'h3, "load zero");
        mem_wr(8'hff, 8'h80);
        wr(REG_INSTR, 32'h3005);
        rdchk(REG_PTR1, 32'hffff, "wrap down");
        rdchk(REG_ACC, 32'h80, "wrap load");
        $display("test modes done");
        mem_wr(8'h3f, 8'h3c);
        wr(REG_PTR0, 32'h20);
        wr(REG_INSTR, 32'h4020);
        rdchk(REG_STATUS, 32'h3, "offset low zero");
        wr(REG_INSTR, 32'h401f);
        rdchk(REG_ACC, 32'h3c, "offset high");
        rdchk(REG_PTR0, 32'h20, "offset ptr kept");
        wr(REG_PTR0, 32'h11);
        wr(REG_INSTR, 32'h2000);
        rdchk(REG_ACC, 32'h51, "window move");
        mem_wr(8'h34, 8'h02);
        wr(REG_PTR1, 32'h34);
        wr(REG_INSTR, 32'h1081);
        mem_chk(8'h34, 8'h01, "window shift");
        rdchk(REG_PTR1, 32'h34, "window ptr kept");
        $display("test window done");
        u_apb_master.xfer(1'b1, 32'h40, 32'hff, rd, err);
        check({31'h0, err}, 32'h1, "unmapped refused");
        u_apb_master.xfer(1'b1, 32'h06, 32'hff, rd, err);
        check({31'h0, err}, 32'h1, "misaligned refused");
        rdchk(REG_ACC, 32'h51, "refused no effect");
        wr(REG_INSTR, 32'h0025);
        rdchk(REG_ACC, 32'h51, "no-op acc kept");
        rdchk(REG_INSTR, 32'h25, "instr readback");
        $display("test refusal done");
        stop_test();
    end
endmodule // tb_shift_move_indirect_exec
